// >>> shared/fsps_params.svh
// Offsets, field positions, reset values and timing counts of the flash self-program sequencer
// Summary of operation
// - Each table read moves exactly one byte
// - Table read copies addressed byte into latch
// - Table pointer optionally auto-updates on table ops
// - Pointer bit zero picks high or low byte
// - Erase always clears a whole 64-byte row
// - Erase row from pointer 21:6, 5:0 ignored
// - Write enable must be set, else inhibit
// - Row-erase select picks erase, else block write
// - Start only after unlock key sequence written
// - Row erase stalls core for about 2 ms
// - Long write halts core, timer ends it
// - Programming works on 16-byte blocks only
// - Sixteen holding bytes; table writes load only them
// - Control register write launches the long write
// - Holding bytes preset to FFh on reset, completion
// - FFh byte unchanged; programming only clears bits
// - Block write stalls core for about 2 ms
// - Pointer 3:0 picks holding byte, upper picks block
// - Start bit set-only; hardware clears on completion
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define FSPS_OFF_PTR      5'h00
`define FSPS_OFF_TBLAT    5'h04
`define FSPS_OFF_MEMCTRL  5'h08
`define FSPS_OFF_UNLOCK   5'h0C
`define FSPS_OFF_TBLOP    5'h10

// ==========================================================================
// Field positions
`define FSPS_MC_SPACE     6
`define FSPS_MC_ROWSEL    4
`define FSPS_MC_ABORT     3
`define FSPS_MC_WEN       2
`define FSPS_MC_WR        1
`define FSPS_OP_DIR       0
`define FSPS_OP_MODE_LO   1

// ==========================================================================
// Values
`define FSPS_KEY_FIRST    8'h55
`define FSPS_KEY_SECOND   8'hAA
`define FSPS_HOLD_RESET   8'hFF
`define FSPS_LATCH_RESET  8'h00
`define FSPS_PTR_W        22
`define FSPS_HOLD_COUNT   16
`define FSPS_ROW_BYTES    64

// ==========================================================================
// Timing
`define FSPS_PROG_TIME_NS   2000000
`define FSPS_CLK_PERIOD_NS  5
`define FSPS_PROG_CYCLES    ((`FSPS_PROG_TIME_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS)

`endif

// >>> shared/fsps_pkg.sv
// Types of the flash self-program sequencer
package fsps_pkg;

  typedef enum logic [1:0] {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } fsps_ptr_mode_t;

  typedef enum logic {
    ST_IDLE,
    ST_FETCH
  } fsps_bus_state_t;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_FIRST,
    KEY_ARMED
  } fsps_key_stage_t;

endpackage : fsps_pkg

// >>> shared/fsps_timer_if.sv
// Handshake between the sequencer and its programming timer
`timescale 1ns/1ps
interface fsps_timer_if;
  logic start;
  logic done;
  logic busy;

  modport ctl   (output start, input done, input busy);
  modport timer (input start, output done, output busy);
endinterface : fsps_timer_if

// >>> src/fsps_prog_timer.sv
// Internal programming timer that ends each long write
`timescale 1ns/1ps
module fsps_prog_timer
  import fsps_pkg::*;
#(
  parameter int unsigned CYCLES = 400000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control handshake
  fsps_timer_if.timer tmr
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("fsps_prog_timer: CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] count_reg;
  logic          running_reg;
  logic          done_reg;

  // ==========================================================================
  // Countdown
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg   <= '0;
      running_reg <= 1'b0;
    end else if (tmr.start && !running_reg) begin
      count_reg   <= CW'(CYCLES - 1);
      running_reg <= 1'b1;
    end else if (running_reg) begin
      if (count_reg == '0) begin
        running_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= running_reg && (count_reg == '0);
    end
  end

  assign tmr.done = done_reg;
  assign tmr.busy = running_reg;

endmodule : fsps_prog_timer

// >>> src/fsps_top.sv
// Flash self-program sequencer: table ops, holding bytes, unlock and long write control
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "fsps_params.svh"
module fsps_top
  import fsps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `FSPS_PROG_CYCLES,
  parameter int unsigned HOLD_COUNT  = `FSPS_HOLD_COUNT,
  parameter int unsigned PTR_W       = `FSPS_PTR_W
) (
  // Clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    NRST_I,
  // Avalon-MM slave
  input  wire logic [4:0]              AVS_ADDRESS_I,
  input  wire logic                    AVS_READ_I,
  input  wire logic                    AVS_WRITE_I,
  input  wire logic [31:0]             AVS_WRITEDATA_I,
  input  wire logic [3:0]              AVS_BYTEENABLE_I,
  output logic      [31:0]             AVS_READDATA_O,
  output logic                         AVS_WAITREQUEST_O,
  // Core stall
  output logic                         CORE_STALL_O,
  // Flash array port
  output logic      [PTR_W-2:0]        FLASH_ADDR_O,
  output logic                         FLASH_RD_O,
  input  wire logic [15:0]             FLASH_RDATA_I,
  output logic                         FLASH_ERASE_O,
  output logic                         FLASH_PROG_O,
  output logic      [8*HOLD_COUNT-1:0] FLASH_WDATA_O,
  output logic      [HOLD_COUNT-1:0]   FLASH_WMASK_O
);

  localparam int unsigned HB       = $clog2(HOLD_COUNT);
  localparam int unsigned ROW_BITS = $clog2(`FSPS_ROW_BYTES);

  generate
    if ((HOLD_COUNT < 2) || ((1 << HB) != HOLD_COUNT) || (HOLD_COUNT > `FSPS_ROW_BYTES)) begin : g_bad_hold
      $error("fsps_top: HOLD_COUNT must be a power of two from 2 to the row size");
    end
    if ((PTR_W < ROW_BITS + 2) || (PTR_W > 32)) begin : g_bad_ptr
      $error("fsps_top: PTR_W out of range");
    end
    if (PROG_CYCLES < 1) begin : g_bad_cycles
      $error("fsps_top: PROG_CYCLES must be at least 1");
    end
  endgenerate

  // ==========================================================================
  // Functions
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a[4:2] == off[4:2]);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Only the low PTR_W-1 bits move; the top bit selects the config space
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input fsps_ptr_mode_t m,
                                                 input logic pre);
    logic [PTR_W-1:0] r;
    r = p;
    if ((pre && (m == PTR_PRE_INC)) || (!pre && (m == PTR_POST_INC))) begin
      r = {p[PTR_W-1], p[PTR_W-2:0] + {{(PTR_W-2){1'b0}}, 1'b1}};
    end else if (!pre && (m == PTR_POST_DEC)) begin
      r = {p[PTR_W-1], p[PTR_W-2:0] - {{(PTR_W-2){1'b0}}, 1'b1}};
    end
    ptr_step = r;
  endfunction : ptr_step

  // ==========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // State
  fsps_bus_state_t  state_reg;
  fsps_key_stage_t  key_reg;
  logic             wait_reg;
  logic [31:0]      rdata_reg;
  logic [PTR_W-1:0] ptr_reg;
  logic [7:0]       latch_reg;
  logic [7:0]       fetch_reg;
  logic [7:0]       hold_mem [HOLD_COUNT];
  logic             space_reg;
  logic             rowsel_reg;
  logic             abort_reg;
  logic             wen_reg;
  logic             wr_reg;
  logic             erase_op_reg;
  logic             tstart_reg;
  logic             rd_pulse_reg;
  logic [PTR_W-2:0] faddr_reg;
  logic             ferase_reg;
  logic             fprog_reg;
  logic [8*HOLD_COUNT-1:0] wdata_reg;
  logic [HOLD_COUNT-1:0]   wmask_reg;

  fsps_timer_if tmr ();

  fsps_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .tmr     (tmr)
  );

  assign tmr.start = tstart_reg;

  // ==========================================================================
  // Bus decode
  logic             req;
  logic             wr_commit;
  logic             op_commit;
  logic             op_is_write;
  logic             op_read_req;
  logic             ready_now;
  logic             mc_wr;
  logic             start_try;
  logic             start_ok;
  logic             done;
  fsps_ptr_mode_t   op_mode;
  logic [PTR_W-1:0] eff_ptr;
  logic [PTR_W-1:0] post_ptr;
  logic [31:0]      ptr_merged;
  logic [31:0]      rd_word;
  logic [7:0]       ctrl_byte;
  logic [8*HOLD_COUNT-1:0] hold_flat;
  logic [HOLD_COUNT-1:0]   hold_mask;

  assign req         = AVS_READ_I | AVS_WRITE_I;
  assign wr_commit   = AVS_WRITE_I && !wait_reg;
  assign op_is_write = AVS_WRITEDATA_I[`FSPS_OP_DIR];
  assign op_mode     = fsps_ptr_mode_t'(AVS_WRITEDATA_I[`FSPS_OP_MODE_LO +: 2]);
  assign op_commit   = wr_commit && hit(AVS_ADDRESS_I, `FSPS_OFF_TBLOP) && AVS_BYTEENABLE_I[0];
  assign op_read_req = AVS_WRITE_I && hit(AVS_ADDRESS_I, `FSPS_OFF_TBLOP) && AVS_BYTEENABLE_I[0] && !op_is_write;
  assign eff_ptr     = ptr_step(ptr_reg, op_mode, 1'b1);
  assign post_ptr    = ptr_step(eff_ptr, op_mode, 1'b0);
  assign ptr_merged  = merge(32'(ptr_reg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign mc_wr       = wr_commit && hit(AVS_ADDRESS_I, `FSPS_OFF_MEMCTRL) && AVS_BYTEENABLE_I[0];
  assign start_try   = mc_wr && AVS_WRITEDATA_I[`FSPS_MC_WR] && !wr_reg;
  assign start_ok    = start_try && AVS_WRITEDATA_I[`FSPS_MC_WEN]
                       && !AVS_WRITEDATA_I[`FSPS_MC_SPACE]
                       && (key_reg == KEY_ARMED);
  assign done        = tmr.done;

  // Long writes hold waitrequest high, which stalls every core access
  assign ready_now = (state_reg == ST_FETCH)
                     || ((state_reg == ST_IDLE) && req && wait_reg && !wr_reg && !op_read_req);

  assign ctrl_byte = {1'b0, space_reg, 1'b0, rowsel_reg, abort_reg, wen_reg, wr_reg, 1'b0};

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(AVS_ADDRESS_I, `FSPS_OFF_PTR)) begin
      rd_word = 32'(ptr_reg);
    end else if (hit(AVS_ADDRESS_I, `FSPS_OFF_TBLAT)) begin
      rd_word = {24'h00_0000, latch_reg};
    end else if (hit(AVS_ADDRESS_I, `FSPS_OFF_MEMCTRL)) begin
      rd_word = {24'h00_0000, ctrl_byte};
    end
  end

  // ==========================================================================
  // Bus handshake
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if ((state_reg == ST_IDLE) && req && wait_reg && !wr_reg && op_read_req) begin
      state_reg <= ST_FETCH;
    end else begin
      state_reg <= ST_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !ready_now;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ready_now) begin
      rdata_reg <= rd_word;
    end
  end

  // ==========================================================================
  // Table read fetch
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rd_pulse_reg <= 1'b0;
    end else begin
      rd_pulse_reg <= (state_reg == ST_IDLE) && req && wait_reg && !wr_reg && op_read_req;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      fetch_reg <= `FSPS_LATCH_RESET;
    end else if (state_reg == ST_FETCH) begin
      fetch_reg <= eff_ptr[0] ? FLASH_RDATA_I[15:8] : FLASH_RDATA_I[7:0];
    end
  end

  // ==========================================================================
  // Table pointer and latch
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= '0;
    end else if (wr_commit && hit(AVS_ADDRESS_I, `FSPS_OFF_PTR)) begin
      ptr_reg <= ptr_merged[PTR_W-1:0];
    end else if (op_commit) begin
      ptr_reg <= post_ptr;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= `FSPS_LATCH_RESET;
    end else if (wr_commit && hit(AVS_ADDRESS_I, `FSPS_OFF_TBLAT) && AVS_BYTEENABLE_I[0]) begin
      latch_reg <= AVS_WRITEDATA_I[7:0];
    end else if (op_commit && !op_is_write) begin
      latch_reg <= fetch_reg;
    end
  end

  // ==========================================================================
  // Holding bytes
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < HOLD_COUNT; i++) begin
        hold_mem[i] <= `FSPS_HOLD_RESET;
      end
    end else if (done) begin
      for (int i = 0; i < HOLD_COUNT; i++) begin
        hold_mem[i] <= `FSPS_HOLD_RESET;
      end
    end else if (op_commit && op_is_write) begin
      hold_mem[eff_ptr[HB-1:0]] <= latch_reg;
    end
  end

  generate
    for (genvar g = 0; g < HOLD_COUNT; g++) begin : g_hold
      assign hold_flat[8*g +: 8] = hold_mem[g];
      assign hold_mask[g]        = (hold_mem[g] != `FSPS_HOLD_RESET);
    end
  endgenerate

  // ==========================================================================
  // Unlock key tracking
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      key_reg <= KEY_NONE;
    end else if (wr_commit) begin
      if (hit(AVS_ADDRESS_I, `FSPS_OFF_UNLOCK) && AVS_BYTEENABLE_I[0]) begin
        if (AVS_WRITEDATA_I[7:0] == `FSPS_KEY_FIRST) begin
          key_reg <= KEY_FIRST;
        end else if ((AVS_WRITEDATA_I[7:0] == `FSPS_KEY_SECOND) && (key_reg == KEY_FIRST)) begin
          key_reg <= KEY_ARMED;
        end else begin
          key_reg <= KEY_NONE;
        end
      end else begin
        key_reg <= KEY_NONE;
      end
    end
  end

  // ==========================================================================
  // Memory control register
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      space_reg <= 1'b0;
      wen_reg   <= 1'b0;
    end else if (mc_wr) begin
      space_reg <= AVS_WRITEDATA_I[`FSPS_MC_SPACE];
      wen_reg   <= AVS_WRITEDATA_I[`FSPS_MC_WEN];
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rowsel_reg <= 1'b0;
    end else if (done && erase_op_reg) begin
      rowsel_reg <= 1'b0;
    end else if (mc_wr) begin
      rowsel_reg <= AVS_WRITEDATA_I[`FSPS_MC_ROWSEL];
    end
  end

  // A refused start sets the flag even when the same write clears it
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
    end else if (mc_wr) begin
      abort_reg <= AVS_WRITEDATA_I[`FSPS_MC_ABORT] || (start_try && !start_ok);
    end else if (done) begin
      abort_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= 1'b0;
    end else if (start_ok) begin
      wr_reg <= 1'b1;
    end else if (done) begin
      wr_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Long write launch
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      erase_op_reg <= 1'b0;
      tstart_reg   <= 1'b0;
    end else begin
      tstart_reg <= start_ok;
      if (start_ok) begin
        erase_op_reg <= AVS_WRITEDATA_I[`FSPS_MC_ROWSEL];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ferase_reg <= 1'b0;
      fprog_reg  <= 1'b0;
    end else if (start_ok) begin
      ferase_reg <= AVS_WRITEDATA_I[`FSPS_MC_ROWSEL];
      fprog_reg  <= !AVS_WRITEDATA_I[`FSPS_MC_ROWSEL];
    end else if (done) begin
      ferase_reg <= 1'b0;
      fprog_reg  <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      faddr_reg <= '0;
    end else if (start_ok) begin
      if (AVS_WRITEDATA_I[`FSPS_MC_ROWSEL]) begin
        faddr_reg <= {ptr_reg[PTR_W-1:ROW_BITS], {(ROW_BITS-1){1'b0}}};
      end else begin
        faddr_reg <= {ptr_reg[PTR_W-1:HB], {(HB-1){1'b0}}};
      end
    end else if ((state_reg == ST_IDLE) && req && wait_reg && !wr_reg && op_read_req) begin
      faddr_reg <= eff_ptr[PTR_W-1:1];
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdata_reg <= '1;
      wmask_reg <= '0;
    end else if (start_ok) begin
      wdata_reg <= hold_flat;
      wmask_reg <= hold_mask;
    end
  end

  // ==========================================================================
  // Outputs
  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign CORE_STALL_O      = wr_reg;
  assign FLASH_ADDR_O      = faddr_reg;
  assign FLASH_RD_O        = rd_pulse_reg;
  assign FLASH_ERASE_O     = ferase_reg;
  assign FLASH_PROG_O      = fprog_reg;
  assign FLASH_WDATA_O     = wdata_reg;
  assign FLASH_WMASK_O     = wmask_reg;

endmodule : fsps_top

// >>> testbench/fsps_flash_model.sv
// Behavioural flash array on the far side of the sequencer's flash port
`timescale 1ns/1ps
module fsps_flash_model (
  // Clock
  input  wire logic         clk_i,
  // Array port
  input  wire logic [20:0]  addr_i,
  input  wire logic         rd_i,
  input  wire logic         erase_i,
  input  wire logic         prog_i,
  input  wire logic [127:0] wdata_i,
  input  wire logic [15:0]  wmask_i,
  output logic      [15:0]  rdata_o
);
  logic [15:0] mem [128];
  logic        tgl_reg = 1'b0;
  logic        er_reg = 1'b0;
  logic        pg_reg = 1'b0;

  // Data lines toggle outside a read so stale data never passes
  assign rdata_o = rd_i ? mem[addr_i[6:0]] : {16{tgl_reg}};

  always @(posedge clk_i) begin
    tgl_reg <= !tgl_reg;
    er_reg <= erase_i;
    pg_reg <= prog_i;
    if (erase_i && !er_reg) begin
      for (int i = 0; i < 32; i++) mem[{addr_i[6:5], 5'(i)}] <= 16'hFFFF;
    end
    if (prog_i && !pg_reg) begin
      for (int j = 0; j < 16; j++) begin
        if (wmask_i[j]) begin
          mem[{addr_i[6:3], 3'(j / 2)}][8*(j%2) +: 8] <= mem[{addr_i[6:3], 3'(j / 2)}][8*(j%2) +: 8] & wdata_i[8*j +: 8];
        end
      end
    end
  end
endmodule : fsps_flash_model

// >>> testbench/fsps_checker.sv
// Port-level assertions of the flash self-program sequencer
`timescale 1ns/1ps
module fsps_checker #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic         CLK_I,
  input wire logic         NRST_I,
  input wire logic [4:0]   AVS_ADDRESS_I,
  input wire logic         AVS_WRITE_I,
  input wire logic [31:0]  AVS_WRITEDATA_I,
  input wire logic         AVS_WAITREQUEST_O,
  input wire logic         CORE_STALL_O,
  input wire logic [20:0]  FLASH_ADDR_O,
  input wire logic         FLASH_RD_O,
  input wire logic         FLASH_ERASE_O,
  input wire logic         FLASH_PROG_O,
  input wire logic [127:0] FLASH_WDATA_O,
  input wire logic [15:0]  FLASH_WMASK_O
);
  int unsigned stall_cnt;
  logic [15:0] mask_exp;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) stall_cnt <= 0;
    else stall_cnt <= CORE_STALL_O ? stall_cnt + 1 : 0;
  end
  always_comb begin
    for (int i = 0; i < 16; i++) mask_exp[i] = FLASH_WDATA_O[8*i +: 8] != 8'hFF;
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_stall_tracks_op: assert property ((FLASH_ERASE_O || FLASH_PROG_O) == CORE_STALL_O)
    else $error("stall differs from flash operation");
  a_long_write_len: assert property ($fell(CORE_STALL_O) |-> stall_cnt >= PROG_CYCLES && stall_cnt <= PROG_CYCLES + 3)
    else $error("long write length wrong");
  a_erase_row_align: assert property ($rose(FLASH_ERASE_O) |-> FLASH_ADDR_O[4:0] == 5'h00)
    else $error("erase address not row aligned");
  a_prog_blk_align: assert property ($rose(FLASH_PROG_O) |-> FLASH_ADDR_O[2:0] == 3'h0)
    else $error("program address not block aligned");
  a_prog_mask_ff: assert property (FLASH_PROG_O |-> FLASH_WMASK_O == mask_exp)
    else $error("write mask does not skip FF bytes");
  a_start_needs_en: assert property ($rose(CORE_STALL_O) |-> $past(AVS_WRITE_I) && $past(AVS_ADDRESS_I) == 5'h08
    && $past(AVS_WRITEDATA_I[2]) && !$past(AVS_WRITEDATA_I[6]))
    else $error("long write began without enabled control write");
  a_op_excl: assert property (!(FLASH_ERASE_O && FLASH_PROG_O))
    else $error("erase and program overlap");
  a_bus_held_busy: assert property (CORE_STALL_O |-> AVS_WAITREQUEST_O)
    else $error("bus answered during long write");
  a_rd_one_pulse: assert property (FLASH_RD_O |=> !FLASH_RD_O)
    else $error("flash read longer than one cycle");
  a_rd_from_op: assert property ($rose(FLASH_RD_O) |-> $past(AVS_WRITE_I) && $past(AVS_ADDRESS_I) == 5'h10
    && !$past(AVS_WRITEDATA_I[0]))
    else $error("flash read without table read");
endmodule : fsps_checker

bind fsps_top fsps_checker #(.PROG_CYCLES(PROG_CYCLES)) u_fsps_checker (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CORE_STALL_O(CORE_STALL_O),
  .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_RD_O(FLASH_RD_O), .FLASH_ERASE_O(FLASH_ERASE_O),
  .FLASH_PROG_O(FLASH_PROG_O), .FLASH_WDATA_O(FLASH_WDATA_O), .FLASH_WMASK_O(FLASH_WMASK_O));

// >>> testbench/tb.sv
// Self-checking bench of the flash self-program sequencer
`timescale 1ns/1ps
`include "fsps_params.svh"
module tb;
  localparam logic [4:0]  A_PTR = `FSPS_OFF_PTR;
  localparam logic [4:0]  A_LAT = `FSPS_OFF_TBLAT;
  localparam logic [4:0]  A_MC = `FSPS_OFF_MEMCTRL;
  localparam logic [4:0]  A_KEY = `FSPS_OFF_UNLOCK;
  localparam logic [4:0]  A_OP = `FSPS_OFF_TBLOP;
  localparam logic [31:0] RMC [4] = '{32'h06, 32'h02, 32'h46, 32'h06};
  logic         CLK_I = 1'b0;
  logic         NRST_I = 1'b0;
  logic [4:0]   AVS_ADDRESS_I = 5'h00;
  logic         AVS_READ_I = 1'b0;
  logic         AVS_WRITE_I = 1'b0;
  logic [31:0]  AVS_WRITEDATA_I = 32'h0;
  logic [3:0]   AVS_BYTEENABLE_I = 4'hF;
  logic [31:0]  AVS_READDATA_O, q;
  logic         AVS_WAITREQUEST_O, CORE_STALL_O, FLASH_RD_O, FLASH_ERASE_O, FLASH_PROG_O;
  logic [20:0]  FLASH_ADDR_O;
  logic [15:0]  FLASH_RDATA_I, FLASH_WMASK_O;
  logic [127:0] FLASH_WDATA_O;
  logic [15:0]  img [128];
  logic [7:0]   hold [16];
  logic [7:0]   last;
  logic [21:0]  ptr, eff;
  int           fails = 0;
  int           check_count = 0;

  always #2.5 CLK_I = !CLK_I;

  fsps_top #(.PROG_CYCLES(20)) u_fsps_top (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CORE_STALL_O(CORE_STALL_O),
    .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_RD_O(FLASH_RD_O), .FLASH_RDATA_I(FLASH_RDATA_I),
    .FLASH_ERASE_O(FLASH_ERASE_O), .FLASH_PROG_O(FLASH_PROG_O), .FLASH_WDATA_O(FLASH_WDATA_O),
    .FLASH_WMASK_O(FLASH_WMASK_O));
  fsps_flash_model u_fsps_flash_model (
    .clk_i(CLK_I), .addr_i(FLASH_ADDR_O), .rd_i(FLASH_RD_O), .erase_i(FLASH_ERASE_O),
    .prog_i(FLASH_PROG_O), .wdata_i(FLASH_WDATA_O), .wmask_i(FLASH_WMASK_O), .rdata_o(FLASH_RDATA_I));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    int n;
    n = 0;
    @(posedge CLK_I);
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_BYTEENABLE_I <= be;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 200);
    q = AVS_READDATA_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    if (n >= 200) begin
      fails++;
      results();
    end
  endtask : bus

  function automatic logic [21:0] step(input logic [21:0] p, input int m);
    step = p;
    if (m == 1 || m == 3) step[20:0] = p[20:0] + 21'h1;
    if (m == 2) step[20:0] = p[20:0] - 21'h1;
  endfunction : step

  function automatic logic [127:0] hv();
    for (int j = 0; j < 16; j++) hv[8*j +: 8] = hold[j];
  endfunction : hv

  task automatic tblop(input int m, input logic wt);
    eff = (m == 3) ? step(ptr, 3) : ptr;
    bus(1'b1, A_OP, {29'h0, m[1:0], wt});
    ptr = step(ptr, m);
  endtask : tblop

  task automatic start(input logic [31:0] mc, input logic st);
    bus(1'b1, A_KEY, {24'h0, `FSPS_KEY_FIRST});
    bus(1'b1, A_KEY, {24'h0, `FSPS_KEY_SECOND});
    bus(1'b1, A_MC, mc);
    @(negedge CLK_I);
    chk(CORE_STALL_O, st);
  endtask : start

  task automatic cmp_img();
    for (int i = 0; i < 128; i++) chk(u_fsps_flash_model.mem[i], img[i]);
  endtask : cmp_img

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(80658));
    for (int i = 0; i < 128; i++) img[i] = 16'($urandom);
    u_fsps_flash_model.mem = img;
    repeat (16) @(posedge CLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk(FLASH_WDATA_O, {128{1'b1}});
    bus(1'b0, A_MC, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h14, 32'hFF);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    ptr = 22'($urandom) & 22'h0000FF;
    bus(1'b1, A_PTR, {10'h0, ptr});
    for (int i = 0; i < 12; i++) begin
      tblop(i % 4, 1'b0);
      bus(1'b0, A_LAT, 32'h0);
      last = img[eff[7:1]][8*eff[0] +: 8];
      chk(q, {24'h0, last});
      bus(1'b0, A_PTR, 32'h0);
      chk(q, {10'h0, ptr});
    end
    bus(1'b1, A_LAT, 32'h5A, 4'hE);
    bus(1'b0, A_LAT, 32'h0);
    chk(q, {24'h0, last});
    for (int k = 0; k < 4; k++) begin
      if (k == 0) bus(1'b1, A_MC, RMC[k]);
      else if (k == 3) begin
        bus(1'b1, A_KEY, 32'h55);
        bus(1'b1, A_PTR, {10'h0, ptr});
        bus(1'b1, A_MC, RMC[k]);
      end
      else start(RMC[k], 1'b0);
      @(negedge CLK_I);
      chk(CORE_STALL_O, 1'b0);
      bus(1'b0, A_MC, 32'h0);
      chk(q, (RMC[k] & 32'h54) | 32'h08);
    end
    ptr = 22'($urandom) & 22'h0000FF;
    bus(1'b1, A_PTR, {10'h0, ptr});
    start(32'h16, 1'b1);
    for (int i = 0; i < 32; i++) img[{ptr[7:6], 5'(i)}] = 16'hFFFF;
    bus(1'b0, A_MC, 32'h0);
    chk(q, 32'h04);
    cmp_img();
    for (int r = 0; r < 3; r++) begin
      for (int j = 0; j < 16; j++) hold[j] = 8'hFF;
      ptr = 22'($urandom) & 22'h0000FF;
      for (int k = 0; k < ((r == 0) ? 16 : 5); k++) begin
        ptr[3:0] = (r == 0) ? 4'(k) : 4'($urandom);
        hold[ptr[3:0]] = (k == 1) ? 8'hFF : 8'($urandom);
        bus(1'b1, A_PTR, {10'h0, ptr});
        bus(1'b1, A_LAT, {24'h0, hold[ptr[3:0]]});
        tblop(0, 1'b1);
      end
      chk(FLASH_PROG_O, 1'b0);
      start(32'h06, 1'b1);
      chk(FLASH_WDATA_O, hv());
      for (int j = 0; j < 16; j++) img[{ptr[7:4], 3'(j / 2)}][8*(j%2) +: 8] &= hold[j];
      bus(1'b0, A_MC, 32'h0);
      chk(q, 32'h04);
      chk(FLASH_WDATA_O, hv());
      cmp_img();
    end
    results();
  end
endmodule : tb
